// file: logic/mmtmr_pkg.sv
package mmtmr_pkg;

  // Register offsets on the plain register port.
  localparam logic [5:0] MMTMR_OFF_A_CTRL = 6'h19;
  localparam logic [5:0] MMTMR_OFF_B_CTRL = 6'h1B;
  localparam logic [5:0] MMTMR_OFF_CD_CTRL = 6'h1D;
  localparam logic [5:0] MMTMR_OFF_A_RELOAD = 6'h1F;
  localparam logic [5:0] MMTMR_OFF_B_RELOAD = 6'h21;
  localparam logic [5:0] MMTMR_OFF_C_RELOAD = 6'h23;
  localparam logic [5:0] MMTMR_OFF_D_RELOAD = 6'h25;
  localparam logic [5:0] MMTMR_OFF_EDGE = 6'h03;

  // Field positions.
  localparam int MMTMR_FORCE_BIT = 4;
  localparam int MMTMR_EDGE_A_BIT = 4;
  localparam int MMTMR_EDGE_B_BIT = 3;
  localparam int MMTMR_CD_C_LSB = 4;

  // Encodings and constants.
  localparam logic [3:0] MMTMR_MODE_STOP = 4'h0;
  localparam logic [3:0] MMTMR_MODE_EVENT = 4'h8;
  localparam logic [7:0] MMTMR_ONE = 8'h01;
  localparam logic [7:0] MMTMR_ZERO8 = 8'h00;
  localparam logic [7:0] MMTMR_PRE_ZERO = 8'h00;

  // Prescaler divide values, index 1 to 7.
  localparam logic [7:0] MMTMR_DIV4 = 8'h04;
  localparam logic [7:0] MMTMR_DIV10 = 8'h0A;
  localparam logic [7:0] MMTMR_DIV16 = 8'h10;
  localparam logic [7:0] MMTMR_DIV50 = 8'h32;
  localparam logic [7:0] MMTMR_DIV64 = 8'h40;
  localparam logic [7:0] MMTMR_DIV100 = 8'h64;
  localparam logic [7:0] MMTMR_DIV200 = 8'hC8;

  // Register port request.
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mmtmr_req_t;

  // State of one timer.
  typedef struct packed {
    logic [7:0] reload;
    logic [7:0] count;
    logic [7:0] pre;
    logic out;
    logic aux_prev;
  } mmtmr_chan_t;

endpackage

// file: logic/mmtmr_top.sv
// What this block does
// - Pulse-width mode: auxiliary interrupt fires on the edge opposite the edge bit.
// - Edge bit one: count while input high; high-to-low stops and interrupts.
// - Reload written while active: finish old count through 01, then load new.
// - Reload write as auxiliary input goes active may corrupt the counter.
// - Outside pulse-width mode the interrupt edge follows the edge bit again.
// - Event-count mode bypasses prescaler; each active edge decrements counter.
// - Counting through 01 in event mode toggles output, pulses, reloads.
// - Edge bit 4 is timer A, bit 3 timer B; one means rising.
// - Changing edge bit in event mode may make a spurious count.
// - In modes 8-15 port interrupt lines 4 and 3 follow aux inputs; port bits unaffected.
// - 8-bit down counters; reload read returns count captured at strobe.
// - Stopped write loads reload and counter; running write loads at 01.
// - Reload write exactly at count-through-01 loads the old reload value into the counter.
// - A/B control bit 4 clears the output two cycles after the write; it stays low until the next toggle.
// - A/B mode: 0 stop, 1-7 delay, 8 event, 9-15 pulse width.
// - Stopped timer keeps counter, discards partial prescaler count.
// - C/D mode: 0 stop, 1-7 delay with prescalers 4 to 200.
// - Upper four bits of A/B control read as zero.
module mmtmr_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Auxiliary inputs and port lines.
  input wire logic timer_a_aux_input,
  input wire logic timer_b_aux_input,
  input wire logic port_line_4,
  input wire logic port_line_3,
  // Timer outputs and time-out pulses.
  output logic timer_a_output,
  output logic timer_b_output,
  output logic timer_c_output,
  output logic timer_d_output,
  output logic [3:0] timeout_pulse,
  // Interrupt channel sources for lines 4 and 3.
  output logic port_interrupt_line_4,
  output logic port_interrupt_line_3
);

  typedef struct packed {
    logic [3:0] a_mode;
    logic [3:0] b_mode;
    logic [2:0] c_mode;
    logic [2:0] d_mode;
    logic a_force;
    logic b_force;
    logic [7:0] edge_sel;
    mmtmr_pkg::mmtmr_chan_t [3:0] ch;
    logic [7:0] rdata;
    logic [3:0] tpulse;
    logic line4_prev;
    logic line3_prev;
    logic irq4;
    logic irq3;
    logic primed;
  } mmtmr_state_t;

  mmtmr_state_t s_q;
  mmtmr_state_t s_d;
  mmtmr_pkg::mmtmr_req_t req;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic [7:0] mmtmr_div(input logic [2:0] sel);
    logic [7:0] r;
    r = mmtmr_pkg::MMTMR_DIV4;
    unique case (sel)
      3'h1: r = mmtmr_pkg::MMTMR_DIV4;
      3'h2: r = mmtmr_pkg::MMTMR_DIV10;
      3'h3: r = mmtmr_pkg::MMTMR_DIV16;
      3'h4: r = mmtmr_pkg::MMTMR_DIV50;
      3'h5: r = mmtmr_pkg::MMTMR_DIV64;
      3'h6: r = mmtmr_pkg::MMTMR_DIV100;
      3'h7: r = mmtmr_pkg::MMTMR_DIV200;
      3'h0: r = mmtmr_pkg::MMTMR_DIV4;
    endcase
    return r;
  endfunction

  always_comb begin
    logic [3:0] mode4 [4];
    logic stopped;
    logic event_m;
    logic pulse_m;
    logic aux;
    logic edge_bit;
    logic active_edge;
    logic cnt_pulse;
    logic run;
    logic wr_reload;
    logic [7:0] div;
    logic [5:0] rel_off [4];
    s_d = s_q;
    stopped = 1'b0;
    event_m = 1'b0;
    pulse_m = 1'b0;
    aux = 1'b0;
    edge_bit = 1'b0;
    active_edge = 1'b0;
    cnt_pulse = 1'b0;
    run = 1'b0;
    wr_reload = 1'b0;
    div = mmtmr_pkg::MMTMR_DIV4;
    mode4[0] = s_q.a_mode;
    mode4[1] = s_q.b_mode;
    mode4[2] = {1'b0, s_q.c_mode};
    mode4[3] = {1'b0, s_q.d_mode};
    rel_off[0] = mmtmr_pkg::MMTMR_OFF_A_RELOAD;
    rel_off[1] = mmtmr_pkg::MMTMR_OFF_B_RELOAD;
    rel_off[2] = mmtmr_pkg::MMTMR_OFF_C_RELOAD;
    rel_off[3] = mmtmr_pkg::MMTMR_OFF_D_RELOAD;
    s_d.tpulse = 4'h0;
    s_d.a_force = 1'b0;
    s_d.b_force = 1'b0;
    // The first cycle after reset only primes the edge detectors, so no false edge follows reset.
    s_d.primed = 1'b1;
    if (req.wr) begin
      unique case (req.addr)
        mmtmr_pkg::MMTMR_OFF_A_CTRL: begin
          s_d.a_mode = req.wdata[3:0];
          s_d.a_force = req.wdata[mmtmr_pkg::MMTMR_FORCE_BIT];
        end
        mmtmr_pkg::MMTMR_OFF_B_CTRL: begin
          s_d.b_mode = req.wdata[3:0];
          s_d.b_force = req.wdata[mmtmr_pkg::MMTMR_FORCE_BIT];
        end
        mmtmr_pkg::MMTMR_OFF_CD_CTRL: begin
          s_d.c_mode = req.wdata[mmtmr_pkg::MMTMR_CD_C_LSB +: 3];
          s_d.d_mode = req.wdata[2:0];
        end
        mmtmr_pkg::MMTMR_OFF_EDGE: begin
          s_d.edge_sel = req.wdata;
        end
        default: begin
        end
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      stopped = (mode4[i] == mmtmr_pkg::MMTMR_MODE_STOP);
      event_m = (i < 2) && (mode4[i] == mmtmr_pkg::MMTMR_MODE_EVENT);
      pulse_m = (i < 2) && mode4[i][3] && !event_m;
      aux = (i == 0) ? timer_a_aux_input : timer_b_aux_input;
      edge_bit = (i == 0) ? s_q.edge_sel[mmtmr_pkg::MMTMR_EDGE_A_BIT]
                          : s_q.edge_sel[mmtmr_pkg::MMTMR_EDGE_B_BIT];
      // The edge detector compares the input, flipped by the edge bit, with its last value.
      active_edge = (aux ^ ~edge_bit) && !s_q.ch[i].aux_prev && s_q.primed;
      div = mmtmr_div(mode4[i][2:0]);
      cnt_pulse = 1'b0;
      run = !stopped && (!pulse_m || (aux == edge_bit));
      if (stopped) begin
        s_d.ch[i].pre = mmtmr_pkg::MMTMR_PRE_ZERO;
      end else if (event_m) begin
        cnt_pulse = active_edge;
        s_d.ch[i].pre = mmtmr_pkg::MMTMR_PRE_ZERO;
      end else if (run) begin
        if (s_q.ch[i].pre + mmtmr_pkg::MMTMR_ONE >= div) begin
          s_d.ch[i].pre = mmtmr_pkg::MMTMR_PRE_ZERO;
          cnt_pulse = 1'b1;
        end else begin
          s_d.ch[i].pre = s_q.ch[i].pre + mmtmr_pkg::MMTMR_ONE;
        end
      end
      if (cnt_pulse) begin
        if (s_q.ch[i].count == mmtmr_pkg::MMTMR_ONE) begin
          s_d.ch[i].count = s_q.ch[i].reload;
          s_d.ch[i].out = ~s_q.ch[i].out;
          s_d.tpulse[i] = 1'b1;
        end else begin
          s_d.ch[i].count = s_q.ch[i].count - mmtmr_pkg::MMTMR_ONE;
        end
      end
      wr_reload = req.wr && (req.addr == rel_off[i]);
      if (wr_reload) begin
        s_d.ch[i].reload = req.wdata;
        // A collision with a count through 01 loads the old reload; the counter takes the written value only when stopped.
        if (stopped) begin
          s_d.ch[i].count = req.wdata;
        end
      end
      s_d.ch[i].aux_prev = (aux ^ ~edge_bit);
    end
    if (s_q.a_force) begin
      s_d.ch[0].out = 1'b0;
    end
    if (s_q.b_force) begin
      s_d.ch[1].out = 1'b0;
    end
    // Interrupt lines 4 and 3: in aux modes the aux input replaces the port line.
    for (int j = 0; j < 2; j++) begin
      aux = (j == 0) ? timer_a_aux_input : timer_b_aux_input;
      edge_bit = (j == 0) ? s_q.edge_sel[mmtmr_pkg::MMTMR_EDGE_A_BIT]
                          : s_q.edge_sel[mmtmr_pkg::MMTMR_EDGE_B_BIT];
      event_m = (mode4[j] == mmtmr_pkg::MMTMR_MODE_EVENT);
      pulse_m = mode4[j][3] && !event_m;
      if (mode4[j][3]) begin
        aux = (j == 0) ? timer_a_aux_input : timer_b_aux_input;
      end else begin
        aux = (j == 0) ? port_line_4 : port_line_3;
      end
      // Pulse-width mode inverts the sense; a mode or edge change may thus cause an edge.
      active_edge = aux ^ ~edge_bit ^ pulse_m;
      if (j == 0) begin
        s_d.irq4 = s_q.primed && active_edge && !s_q.line4_prev;
        s_d.line4_prev = active_edge;
      end else begin
        s_d.irq3 = s_q.primed && active_edge && !s_q.line3_prev;
        s_d.line3_prev = active_edge;
      end
    end
    // Read data for the cycle after the strobe; data reads show the live counter.
    s_d.rdata = mmtmr_pkg::MMTMR_ZERO8;
    if (req.rd) begin
      unique case (req.addr)
        mmtmr_pkg::MMTMR_OFF_A_CTRL: s_d.rdata = {4'h0, s_q.a_mode};
        mmtmr_pkg::MMTMR_OFF_B_CTRL: s_d.rdata = {4'h0, s_q.b_mode};
        mmtmr_pkg::MMTMR_OFF_CD_CTRL: s_d.rdata = {1'b0, s_q.c_mode, 1'b0, s_q.d_mode};
        mmtmr_pkg::MMTMR_OFF_EDGE: s_d.rdata = s_q.edge_sel;
        mmtmr_pkg::MMTMR_OFF_A_RELOAD: s_d.rdata = s_q.ch[0].count;
        mmtmr_pkg::MMTMR_OFF_B_RELOAD: s_d.rdata = s_q.ch[1].count;
        mmtmr_pkg::MMTMR_OFF_C_RELOAD: s_d.rdata = s_q.ch[2].count;
        mmtmr_pkg::MMTMR_OFF_D_RELOAD: s_d.rdata = s_q.ch[3].count;
        default: s_d.rdata = mmtmr_pkg::MMTMR_ZERO8;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs.
  assign reg_rdata = s_q.rdata;
  assign timer_a_output = s_q.ch[0].out;
  assign timer_b_output = s_q.ch[1].out;
  assign timer_c_output = s_q.ch[2].out;
  assign timer_d_output = s_q.ch[3].out;
  assign timeout_pulse = s_q.tpulse;
  assign port_interrupt_line_4 = s_q.irq4;
  assign port_interrupt_line_3 = s_q.irq3;

endmodule

// file: tb/mmtmr_aux_src.sv
module mmtmr_aux_src (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Requested level and the driven line.
  input wire logic want,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] gap_q;
  // The line follows the request but changes at most once per four clocks.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      line <= 1'b0;
      gap_q <= 3'h0;
    end else if (want != line && gap_q >= 3'h3) begin
      line <= want;
      gap_q <= 3'h0;
    end else if (gap_q != 3'h7) begin
      gap_q <= gap_q + 3'h1;
    end
  end
endmodule

// file: tb/mmtmr_properties.sv
module mmtmr_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins.
  input wire logic timer_a_aux_input,
  input wire logic port_line_3,
  input wire logic timer_a_output,
  input wire logic [3:0] timeout_pulse,
  input wire logic port_interrupt_line_4,
  input wire logic port_interrupt_line_3
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mode_a_q;
  logic [3:0] mode_b_q;
  logic [7:0] edge_q;
  logic at_a;
  assign at_a = reg_addr == mmtmr_pkg::MMTMR_OFF_A_CTRL;
  // Shadows the A and B mode fields and the edge register that software has written.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_a_q <= 4'h0;
      mode_b_q <= 4'h0;
      edge_q <= 8'h00;
    end else if (reg_wr) begin
      if (at_a) mode_a_q <= reg_wdata[3:0];
      if (reg_addr == mmtmr_pkg::MMTMR_OFF_B_CTRL) mode_b_q <= reg_wdata[3:0];
      if (reg_addr == mmtmr_pkg::MMTMR_OFF_EDGE) edge_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_upper;
    reg_rd && at_a |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("control upper bits set");
  property p_force;
    reg_wr && at_a && reg_wdata[4] |-> ##2 !timer_a_output;
  endproperty
  a_force: assert property (p_force) else $error("force left output high");
  property p_toggle;
    timeout_pulse[0] && mode_a_q == mmtmr_pkg::MMTMR_MODE_EVENT |-> timer_a_output != $past(timer_a_output);
  endproperty
  a_toggle: assert property (p_toggle) else $error("time-out without toggle");
  property p_stop;
    (mode_a_q == 4'h0) [*3] |-> !timeout_pulse[0];
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer timed out");
  property p_pw_irq;
    mode_a_q[3] && mode_a_q[2:0] != 3'h0 && edge_q[4] && $fell(timer_a_aux_input) |-> ##[0:2] port_interrupt_line_4;
  endproperty
  a_pw_irq: assert property (p_pw_irq) else $error("no interrupt at pulse end");
  property p_evt_irq;
    mode_a_q == 4'h8 && edge_q[4] && $rose(timer_a_aux_input) |-> ##[0:2] port_interrupt_line_4;
  endproperty
  a_evt_irq: assert property (p_evt_irq) else $error("no interrupt on active edge");
  property p_port_irq;
    mode_b_q == 4'h0 && edge_q[3] && $rose(port_line_3) |-> ##[0:2] port_interrupt_line_3;
  endproperty
  a_port_irq: assert property (p_port_irq) else $error("no port line interrupt");
  property p_reset;
    $rose(nrst) |-> !timer_a_output && timeout_pulse == 4'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("state not cleared by reset");
  c_timeout_a: cover property (timeout_pulse[0]);
  c_irq_4: cover property (port_interrupt_line_4);
  c_timeout_d: cover property (timeout_pulse[3]);
endmodule
bind mmtmr_top mmtmr_checker i_mmtmr_checker (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .timer_a_aux_input, .port_line_3, .timer_a_output, .timeout_pulse, .port_interrupt_line_4, .port_interrupt_line_3);

// file: tb/test_mmtmr_top.sv
module test_mmtmr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic want_a = 1'b0;
  logic timer_b_aux_input = 1'b0;
  logic port_line_4 = 1'b0;
  logic port_line_3 = 1'b0;
  logic [7:0] reg_rdata;
  logic timer_a_aux_input;
  logic timer_a_output;
  logic timer_b_output;
  logic timer_c_output;
  logic timer_d_output;
  logic [3:0] timeout_pulse;
  logic port_interrupt_line_4;
  logic port_interrupt_line_3;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int n_irq4 = 0;
  int irq4_base = 0;
  logic [3:0] tmr_out;
  assign tmr_out = {timer_d_output, timer_c_output, timer_b_output, timer_a_output};
  localparam logic [7:0] div_tab [7] = '{8'h04, 8'h0A, 8'h10, 8'h32, 8'h40, 8'h64, 8'hC8};
  mmtmr_top i_mmtmr_top (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer_a_aux_input,
    .timer_b_aux_input, .port_line_4, .port_line_3, .timer_a_output, .timer_b_output, .timer_c_output,
    .timer_d_output, .timeout_pulse, .port_interrupt_line_4, .port_interrupt_line_3);
  mmtmr_aux_src i_mmtmr_aux_src (.clk, .nrst, .want(want_a), .line(timer_a_aux_input));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (port_interrupt_line_4) begin
      n_irq4 <= n_irq4 + 1;
    end
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic aux_a(input int n);
    repeat (n) begin
      @(posedge clk);
      want_a <= 1'b1;
      repeat (6) @(posedge clk);
      want_a <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask
  task automatic period(input int idx, input logic [7:0] exp);
    int n;
    logic was;
    n = 0;
    do begin
      @(posedge clk);
      #1;
    end while (timeout_pulse[idx] !== 1'b1 && ++n < 500);
    was = tmr_out[idx];
    n = 0;
    do begin
      @(posedge clk);
      #1;
    end while (timeout_pulse[idx] !== 1'b1 && ++n < 500);
    chk(8'(n + 1), exp);
    chk(8'(tmr_out[idx] ^ was), 8'h01);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(mmtmr_pkg::MMTMR_OFF_A_CTRL, 8'h00);
    rd(mmtmr_pkg::MMTMR_OFF_CD_CTRL, 8'h00);
    rd(6'h3F, 8'h00);
    wr(mmtmr_pkg::MMTMR_OFF_A_CTRL, 8'hFF);
    rd(mmtmr_pkg::MMTMR_OFF_A_CTRL, 8'h0F);
    wr(mmtmr_pkg::MMTMR_OFF_A_CTRL, 8'h00);
    $display("reset and control test done");
    wr(mmtmr_pkg::MMTMR_OFF_EDGE, 8'h18);
    wr(mmtmr_pkg::MMTMR_OFF_A_RELOAD, 8'h05);
    rd(mmtmr_pkg::MMTMR_OFF_A_RELOAD, 8'h05);
    wr(mmtmr_pkg::MMTMR_OFF_A_CTRL, 8'h08);
    irq4_base = n_irq4;
    aux_a(3);
    rd(mmtmr_pkg::MMTMR_OFF_A_RELOAD, 8'h02);
    chk(8'(n_irq4 - irq4_base), 8'h03);
    wr(mmtmr_pkg::MMTMR_OFF_A_RELOAD, 8'h09);
    rd(mmtmr_pkg::MMTMR_OFF_A_RELOAD, 8'h02);
    aux_a(2);
    rd(mmtmr_pkg::MMTMR_OFF_A_RELOAD, 8'h09);
    chk(8'(timer_a_output), 8'h01);
    wr(mmtmr_pkg::MMTMR_OFF_A_CTRL, 8'h18);
    @(posedge clk);
    #1 chk(8'(timer_a_output), 8'h00);
    aux_a(1);
    wr(mmtmr_pkg::MMTMR_OFF_A_CTRL, 8'h00);
    aux_a(2);
    rd(mmtmr_pkg::MMTMR_OFF_A_RELOAD, 8'h08);
    $display("event count test done");
    for (int k = 9; k < 16; k++) wr(mmtmr_pkg::MMTMR_OFF_A_CTRL, 8'(k));
    irq4_base = n_irq4;
    aux_a(1);
    wr(mmtmr_pkg::MMTMR_OFF_A_CTRL, 8'h00);
    @(posedge clk);
    port_line_3 <= 1'b1;
    @(posedge clk);
    #1 chk(8'(port_interrupt_line_3), 8'h01);
    chk(8'(n_irq4 - irq4_base), 8'h01);
    repeat (2) @(posedge clk);
    $display("pulse width and port line test done");
    wr(mmtmr_pkg::MMTMR_OFF_B_RELOAD, 8'h01);
    wr(mmtmr_pkg::MMTMR_OFF_C_RELOAD, 8'h01);
    wr(mmtmr_pkg::MMTMR_OFF_D_RELOAD, 8'h01);
    for (int k = 1; k < 8; k++) begin
      wr(mmtmr_pkg::MMTMR_OFF_B_CTRL, 8'(k));
      wr(mmtmr_pkg::MMTMR_OFF_CD_CTRL, 8'((k << 4) | k));
      period(1, div_tab[k - 1]);
      period(2, div_tab[k - 1]);
      period(3, div_tab[k - 1]);
    end
    $display("delay prescaler test done");
    give_verdict();
  end
endmodule
